// >>> rtl/stepper_ramp_pkg.sv
// constants, types and tables shared by the stepper pulse and ramp controller
// Operation
// - both ramps on and short count: decelerate after half the pulses, ramps mirrored.
// - accelerate only and short count: stop at the rate the ramp reached.
// - decelerate only and short count: follow the deceleration curve, then stop.
// - step period is a twelve-bit field in 2.0 us units, 0 to 8190 us.
// - a zero period field emits no pulses and holds the drive state.
// - the period is the time of one step in every excitation mode.
// - the command is chosen by the top four bits; the rest are data.
// - the pulse count is a twelve-bit field, 0 to 4095.
// - the count is multiplied by the factor and that many pulses counted.
// - the monitor output shows every counted pulse, up to 4095 times the factor.
// - a zero count field emits no pulses and holds the drive state.
// - motor 2 words on bridges three and four behave like the motor-1 words.
// - motor-2 drive word: direction, stop mode, enable, mode, constant current, current.
// - ramp word: bit 10 accelerate, bit 9 decelerate, 8..2 shape, 1..0 multiplier.
// - pin control mode stays off after reset until its word is written.
// - in pin control mode bridges five and six drive input AND duty.
// - phase current is positive flowing from terminal A to terminal B.
// - in pin control mode bridge seven chops against the current sense input.
// - multiplier codes 00 and 01 give 1, 10 gives 2, 11 gives 4.
// - at startup x1 each full ramp takes 94 pulses.
`default_nettype none

package stepper_ramp_pkg;

    // command addresses, upper four bits of each word
    localparam logic [3:0] ADDR_EXT_MODE              = 4'h1;
    localparam logic [3:0] ADDR_DUTY5                 = 4'h5;
    localparam logic [3:0] ADDR_DUTY6                 = 4'h6;
    localparam logic [3:0] ADDR_STEPPER1_DRIVE_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_STEPPER1_RAMP_PROFILE  = 4'h9;
    localparam logic [3:0] ADDR_STEPPER1_PULSE_PERIOD  = 4'hA;
    localparam logic [3:0] ADDR_STEPPER1_PULSE_COUNT   = 4'hB;
    localparam logic [3:0] ADDR_STEPPER2_DRIVE_CONTROL = 4'hC;
    localparam logic [3:0] ADDR_STEPPER2_RAMP_PROFILE  = 4'hD;
    localparam logic [3:0] ADDR_STEPPER2_PULSE_PERIOD  = 4'hE;
    localparam logic [3:0] ADDR_STEPPER2_PULSE_COUNT   = 4'hF;

    // word layout
    localparam int WORD_W      = 16;
    localparam int ADDR_LSB    = 12;
    localparam int DATA_W      = 12;
    localparam int FIELD_W     = 11;
    localparam int DUTY_W      = 8;
    localparam int EXT_MODE_BIT = 0;
    localparam int TOTAL_W     = 14;
    localparam int POS_W       = 9;
    localparam int PERIOD_UNITS_W = 20;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    // timing: one period unit is 2.0 us
    localparam int CLK_PERIOD_NS  = 50;
    localparam int PERIOD_RES_NS  = 2000;
    localparam int TICK_CYCLES    = PERIOD_RES_NS / CLK_PERIOD_NS;
    localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

    // ramp shape
    localparam int RAMP_STEPS  = 15;
    localparam int RAMP_PULSES = 94;
    localparam logic [7:0] STEP_PULSES [3][RAMP_STEPS] = '{
        '{8'h02, 8'h05, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
          8'h01, 8'h01, 8'h02, 8'h03, 8'h0B, 8'h1F, 8'h1F},
        '{8'h01, 8'h04, 8'h04, 8'h03, 8'h02, 8'h02, 8'h02, 8'h02,
          8'h02, 8'h02, 8'h04, 8'h06, 8'h0C, 8'h11, 8'h1F},
        '{8'h01, 8'h03, 8'h03, 8'h04, 8'h03, 8'h04, 8'h03, 8'h03,
          8'h03, 8'h03, 8'h05, 8'h09, 8'h0D, 8'h0F, 8'h16}};
    localparam logic [6:0] STEP_INCR [RAMP_STEPS] = '{
        7'h78, 7'h38, 7'h23, 7'h18, 7'h12, 7'h0D, 7'h0A, 7'h08,
        7'h07, 7'h06, 7'h05, 7'h04, 7'h03, 7'h02, 7'h01};

    // drive control word, bits 10..0
    typedef struct packed {
        logic       cc_switch;
        logic [1:0] drive_mode;
        logic       out_enable;
        logic       stop_mode;
        logic       direction;
        logic [4:0] current;
    } drive_ctrl_t;

    // ramp profile word, bits 10..0
    typedef struct packed {
        logic       accel_enable_bit;
        logic       decel_enable_bit;
        logic [1:0] startup;
        logic [1:0] table_sel;
        logic [2:0] ref_sel;
        logic [1:0] mult;
    } ramp_cfg_t;

    typedef struct packed {
        logic [DATA_W-1:0] period;
        logic [DATA_W-1:0] count;
    } motion_cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_ACCEL  = 4'b0010,
        ST_CRUISE = 4'b0100,
        ST_DECEL  = 4'b1000
    } ramp_state_t;

endpackage

`default_nettype wire

// >>> rtl/step_pulse_gen.sv
// one motor's step pulse generator with acceleration and deceleration ramps
`default_nettype none

module step_pulse_gen
    import stepper_ramp_pkg::*;
(
    // clock and control
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        ce_in,
    input  wire logic        start_in,
    input  wire logic        abort_in,
    // settings
    input  wire ramp_cfg_t   cfg_in,
    input  wire motion_cmd_t cmd_in,
    // status
    output logic             step_out,
    output logic             busy_out
);

    ramp_state_t              state;
    logic [1:0]               mult_shift;
    logic [1:0]               start_shift;
    logic [2:0]               ref_shift;
    logic [1:0]               tbl;
    logic [TOTAL_W-1:0]       total;
    logic [TOTAL_W-1:0]       remaining;
    logic [TOTAL_W-1:0]       next_remaining;
    logic [POS_W-1:0]         ramp_len;
    logic [POS_W-1:0]         ramp_pos;
    logic [POS_W-1:0]         look_pos;
    logic [6:0]               incr;
    logic [PERIOD_UNITS_W-1:0] period_units;
    logic [PERIOD_UNITS_W-1:0] timer;
    logic [5:0]               prescale;
    logic                     tick;
    logic                     fire;

    always_comb begin
        mult_shift  = cfg_in.mult[1] ? (cfg_in.mult[0] ? 2'h2 : 2'h1) : 2'h0;
        start_shift = cfg_in.startup[1] ? (cfg_in.startup[0] ? 2'h2 : 2'h1) : 2'h0;
        tbl         = cfg_in.table_sel[1] ? (cfg_in.table_sel[0] ? 2'h2 : 2'h1) : 2'h0;
        unique case (cfg_in.ref_sel)
            3'h3:    ref_shift = 3'h2;
            3'h4:    ref_shift = 3'h3;
            3'h5:    ref_shift = 3'h4;
            3'h6,
            3'h7:    ref_shift = 3'h5;
            default: ref_shift = 3'h1;
        endcase
    end

    function automatic logic [6:0] incr_of(input logic [POS_W-1:0] pos, input logic [1:0] t);
        logic [POS_W-1:0] acc;
        logic [6:0]       r;
        logic             hit;
        acc = '0;
        r   = '0;
        hit = 1'b0;
        for (int k = 0; k < RAMP_STEPS; k++) begin
            acc = acc + POS_W'(STEP_PULSES[t][k]);
            if (!hit && pos < acc) begin
                r   = STEP_INCR[k];
                hit = 1'b1;
            end
        end
        return r;
    endfunction

    assign total    = TOTAL_W'(cmd_in.count) << mult_shift;
    assign ramp_len = POS_W'(RAMP_PULSES) << start_shift;
    // deceleration walks the curve backwards by pulses still to go
    assign look_pos = (state == ST_DECEL) ? ramp_pos - 1'b1 : ramp_pos;
    assign incr     = (state == ST_CRUISE) ? 7'h00 : incr_of(look_pos >> start_shift, tbl);
    assign period_units = PERIOD_UNITS_W'(cmd_in.period)
                        + PERIOD_UNITS_W'(cmd_in.period >> ref_shift)
                        * PERIOD_UNITS_W'(incr);
    assign tick     = (prescale == TICK_LAST);
    // a zero period stalls the run and leaves the drive state untouched
    assign fire     = (state != ST_IDLE) && tick && (cmd_in.period != '0)
                    && (timer >= period_units - 1'b1);
    assign next_remaining = remaining - 1'b1;
    assign busy_out = (state != ST_IDLE);

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            prescale <= '0;
        end else if (ce_in) begin
            prescale <= (tick || state == ST_IDLE) ? 6'h00 : prescale + 6'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            timer <= '0;
        end else if (ce_in) begin
            if (state == ST_IDLE || fire) begin
                timer <= '0;
            end else if (tick) begin
                timer <= timer + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            step_out <= 1'b0;
        end else if (ce_in) begin
            step_out <= fire;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state     <= ST_IDLE;
            remaining <= '0;
            ramp_pos  <= '0;
        end else if (ce_in) begin
            if (abort_in) begin
                state <= ST_IDLE;
            end else if (start_in) begin
                remaining <= total;
                // zero count or period never leaves idle
                if (total == '0 || cmd_in.period == '0) begin
                    state <= ST_IDLE;
                end else if (cfg_in.accel_enable_bit) begin
                    state    <= ST_ACCEL;
                    ramp_pos <= '0;
                end else if (cfg_in.decel_enable_bit && total <= TOTAL_W'(ramp_len)) begin
                    state    <= ST_DECEL;
                    ramp_pos <= POS_W'(total);
                end else begin
                    state <= ST_CRUISE;
                end
            end else if (fire) begin
                remaining <= next_remaining;
                unique case (state)
                    ST_ACCEL: begin
                        ramp_pos <= ramp_pos + 1'b1;
                        if (next_remaining == '0) begin
                            state <= ST_IDLE;
                        end else if (cfg_in.decel_enable_bit
                                     && next_remaining <= TOTAL_W'(ramp_pos + 1'b1)) begin
                            state    <= ST_DECEL;
                            ramp_pos <= POS_W'(next_remaining);
                        end else if (ramp_pos + 1'b1 == ramp_len) begin
                            state <= ST_CRUISE;
                        end
                    end
                    ST_CRUISE: begin
                        if (next_remaining == '0) begin
                            state <= ST_IDLE;
                        end else if (cfg_in.decel_enable_bit
                                     && next_remaining <= TOTAL_W'(ramp_len)) begin
                            state    <= ST_DECEL;
                            ramp_pos <= POS_W'(next_remaining);
                        end
                    end
                    ST_DECEL: begin
                        ramp_pos <= POS_W'(next_remaining);
                        if (next_remaining == '0) begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_IDLE: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// >>> rtl/stepper_pulse_ramp_control.sv
// serial command decoder, two stepper ramp channels and pin-controlled bridges
`default_nettype none

module stepper_pulse_ramp_control
    import stepper_ramp_pkg::*;
(
    // clock, reset, enable
    input  wire logic        SYS_CLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic        CE_IN,
    // serial command port
    input  wire logic        SCLK_IN,
    input  wire logic        SDATA_IN,
    input  wire logic        LATCH_IN,
    // external pin control inputs, bit 1 is input A, bit 0 is input B
    input  wire logic [1:0]  BRIDGE5_IN,
    input  wire logic [1:0]  BRIDGE6_IN,
    input  wire logic [1:0]  BRIDGE7_IN,
    input  wire logic        CURRENT_SENSE_INPUT_IN,
    // stepper 1 (bridges one and two)
    output logic             STEP1_OUT,
    output logic             BUSY1_OUT,
    output logic [5:0]       PHASE1_OUT,
    output drive_ctrl_t      DRIVE1_OUT,
    output logic             PULSE_MONITOR_OUT_FIRST_OUT,
    // stepper 2 (bridges three and four)
    output logic             STEP2_OUT,
    output logic             BUSY2_OUT,
    output logic [5:0]       PHASE2_OUT,
    output drive_ctrl_t      DRIVE2_OUT,
    output logic             PULSE_MONITOR_OUT_SECOND_OUT,
    // bridges five to seven
    output logic             EXT_MODE_OUT,
    output logic [1:0]       BRIDGE5_OUT,
    output logic [1:0]       BRIDGE6_OUT,
    output logic [1:0]       BRIDGE7_OUT
);

    // serial shifter
    logic                 sclk_q;
    logic                 latch_q;
    logic [WORD_W-1:0]    shift_reg;
    logic [4:0]           bit_cnt;
    logic                 frame_done;
    logic [3:0]           word_addr;
    logic [FIELD_W-1:0]   word_field;
    logic [DATA_W-1:0]    word_data;

    // command registers
    logic                 ext_mode;
    logic [DUTY_W-1:0]    duty [2];
    drive_ctrl_t          drive [2];
    ramp_cfg_t            ramp [2];
    motion_cmd_t          motion [2];
    logic [1:0]           start;
    logic [1:0]           abort;
    logic [1:0]           step;
    logic [1:0]           busy;
    logic [5:0]           phase [2];

    // bridge drive
    logic [DUTY_W-1:0]    pwm_cnt;
    logic [1:0]           pwm_on;
    logic                 chop;
    logic [1:0]           next_bridge [3];
    logic [1:0]           bridge_q [3];

    assign word_addr  = shift_reg[WORD_W-1:ADDR_LSB];
    assign word_field = shift_reg[FIELD_W-1:0];
    assign word_data  = shift_reg[DATA_W-1:0];
    // the word is taken only if exactly a full frame was clocked in
    assign frame_done = latch_q && !LATCH_IN && (bit_cnt == FRAME_BITS);

    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            sclk_q  <= 1'b0;
            latch_q <= 1'b0;
        end else if (CE_IN) begin
            sclk_q  <= SCLK_IN;
            latch_q <= LATCH_IN;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            shift_reg <= '0;
            bit_cnt   <= '0;
        end else if (CE_IN) begin
            if (!LATCH_IN) begin
                bit_cnt <= '0;
            end else if (SCLK_IN && !sclk_q) begin
                shift_reg <= {shift_reg[WORD_W-2:0], SDATA_IN};
                // extra clocks spoil the frame rather than slide the word
                bit_cnt   <= (bit_cnt > FRAME_BITS) ? bit_cnt : bit_cnt + 5'h01;
            end
        end
    end

    // pin control mode and duty words
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            ext_mode <= 1'b0;
            duty[0]  <= '0;
            duty[1]  <= '0;
        end else if (CE_IN && frame_done) begin
            if (word_addr == ADDR_EXT_MODE) begin
                ext_mode <= shift_reg[EXT_MODE_BIT];
            end
            if (word_addr == ADDR_DUTY5) begin
                duty[0] <= shift_reg[DUTY_W-1:0];
            end
            if (word_addr == ADDR_DUTY6) begin
                duty[1] <= shift_reg[DUTY_W-1:0];
            end
        end
    end

    // both steppers share one word layout, differing only in address
    for (genvar m = 0; m < 2; m++) begin : g_motor
        localparam logic [3:0] A_CTRL   = m ? ADDR_STEPPER2_DRIVE_CONTROL
                                            : ADDR_STEPPER1_DRIVE_CONTROL;
        localparam logic [3:0] A_RAMP   = m ? ADDR_STEPPER2_RAMP_PROFILE
                                            : ADDR_STEPPER1_RAMP_PROFILE;
        localparam logic [3:0] A_PERIOD = m ? ADDR_STEPPER2_PULSE_PERIOD
                                            : ADDR_STEPPER1_PULSE_PERIOD;
        localparam logic [3:0] A_COUNT  = m ? ADDR_STEPPER2_PULSE_COUNT
                                            : ADDR_STEPPER1_PULSE_COUNT;

        always_ff @(posedge SYS_CLK_IN) begin
            if (!NRST_IN) begin
                drive[m]  <= '0;
                ramp[m]   <= '0;
                motion[m] <= '0;
            end else if (CE_IN && frame_done) begin
                if (word_addr == A_CTRL) begin
                    drive[m] <= drive_ctrl_t'(word_field);
                end
                if (word_addr == A_RAMP) begin
                    ramp[m] <= ramp_cfg_t'(word_field);
                end
                if (word_addr == A_PERIOD) begin
                    motion[m].period <= word_data;
                end
                if (word_addr == A_COUNT) begin
                    motion[m].count <= word_data;
                end
            end
        end

        // a count word launches a run with the settings then in force
        always_ff @(posedge SYS_CLK_IN) begin
            if (!NRST_IN) begin
                start[m] <= 1'b0;
            end else if (CE_IN) begin
                start[m] <= frame_done && (word_addr == A_COUNT);
            end
        end

        // disabling the outputs cancels the run in progress
        assign abort[m] = !drive[m].out_enable;

        step_pulse_gen u_gen (
            .clk_in   (SYS_CLK_IN),
            .nrst_in  (NRST_IN),
            .ce_in    (CE_IN),
            .start_in (start[m]),
            .abort_in (abort[m]),
            .cfg_in   (ramp[m]),
            .cmd_in   (motion[m]),
            .step_out (step[m]),
            .busy_out (busy[m])
        );

        // forward steps advance the phase so current flows A to B first
        always_ff @(posedge SYS_CLK_IN) begin
            if (!NRST_IN) begin
                phase[m] <= '0;
            end else if (CE_IN && step[m]) begin
                phase[m] <= drive[m].direction ? phase[m] + 6'h01
                                               : phase[m] - 6'h01;
            end
        end
    end

    // shared PWM time base for bridges five to seven
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            pwm_cnt <= '0;
        end else if (CE_IN) begin
            pwm_cnt <= pwm_cnt + 1'b1;
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_duty
        assign pwm_on[c] = (pwm_cnt < duty[c]);
    end

    // over-current latches off the bridge until the next PWM period begins
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            chop <= 1'b0;
        end else if (CE_IN) begin
            if (CURRENT_SENSE_INPUT_IN) begin
                chop <= 1'b1;
            end else if (pwm_cnt == '1) begin
                chop <= 1'b0;
            end
        end
    end

    always_comb begin
        next_bridge[0] = 2'h0;
        next_bridge[1] = 2'h0;
        next_bridge[2] = 2'h0;
        if (ext_mode) begin
            next_bridge[0] = BRIDGE5_IN & {2{pwm_on[0]}};
            next_bridge[1] = BRIDGE6_IN & {2{pwm_on[1]}};
            // brake needs no chopping; only a driven direction is cut back
            next_bridge[2] = (chop && (BRIDGE7_IN != 2'h3)) ? 2'h0 : BRIDGE7_IN;
        end
    end

    for (genvar b = 0; b < 3; b++) begin : g_bridge
        always_ff @(posedge SYS_CLK_IN) begin
            if (!NRST_IN) begin
                bridge_q[b] <= '0;
            end else if (CE_IN) begin
                bridge_q[b] <= next_bridge[b];
            end
        end
    end

    assign STEP1_OUT                    = step[0];
    assign BUSY1_OUT                    = busy[0];
    assign PHASE1_OUT                   = phase[0];
    assign DRIVE1_OUT                   = drive[0];
    assign PULSE_MONITOR_OUT_FIRST_OUT  = step[0];
    assign STEP2_OUT                    = step[1];
    assign BUSY2_OUT                    = busy[1];
    assign PHASE2_OUT                   = phase[1];
    assign DRIVE2_OUT                   = drive[1];
    assign PULSE_MONITOR_OUT_SECOND_OUT = step[1];
    assign EXT_MODE_OUT                 = ext_mode;
    assign BRIDGE5_OUT                  = bridge_q[0];
    assign BRIDGE6_OUT                  = bridge_q[1];
    assign BRIDGE7_OUT                  = bridge_q[2];

endmodule

`default_nettype wire

// >>> testbench/host_serial_model.sv
// host model that shifts 16-bit command words into the serial port
`default_nettype none
module host_serial_model (
    input  wire logic clk_in,
    output var logic  sclk_out,
    output var logic  sdata_out,
    output var logic  latch_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        latch_out = 1'b0;
    end
    // msb first, one word per latch window; clock stays low between frames
    task automatic send(input logic [15:0] w);
        @(posedge clk_in);
        latch_out <= 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_in);
            sdata_out <= w[i];
            sclk_out <= 1'b0;
            @(posedge clk_in);
            sclk_out <= 1'b1;
        end
        @(posedge clk_in);
        sclk_out <= 1'b0;
        @(posedge clk_in);
        latch_out <= 1'b0;
        sdata_out <= ~w[0];
        repeat (2) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// >>> testbench/stepper_pulse_ramp_control_props.sv
// port assertions for the stepper pulse and ramp controller
`default_nettype none
module stepper_pulse_ramp_control_props (
    input wire logic       SYS_CLK_IN,
    input wire logic       NRST_IN,
    input wire logic [1:0] BRIDGE5_IN,
    input wire logic [1:0] BRIDGE7_IN,
    input wire logic       CURRENT_SENSE_INPUT_IN,
    input wire logic       STEP1_OUT,
    input wire logic       BUSY1_OUT,
    input wire logic       STEP2_OUT,
    input wire logic       BUSY2_OUT,
    input wire logic       EXT_MODE_OUT,
    input wire logic [1:0] BRIDGE5_OUT,
    input wire logic [1:0] BRIDGE6_OUT,
    input wire logic [1:0] BRIDGE7_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    a_step_spacing: assert property (STEP1_OUT |=> !STEP1_OUT [*8])
        else $error("step pulses too close");
    // the last step shows in the same cycle that busy drops, so busy is checked one cycle earlier
    a_step_in_run: assert property (STEP1_OUT |-> $past(BUSY1_OUT))
        else $error("step outside a run");
    a_run_ends: assert property ($fell(BUSY1_OUT) |-> STEP1_OUT)
        else $error("run ended without a last step");
    a_motor2_step: assert property (STEP2_OUT |-> $past(BUSY2_OUT) ##1 !STEP2_OUT [*8])
        else $error("motor 2 step malformed");
    a_motor2_end: assert property ($fell(BUSY2_OUT) |-> STEP2_OUT)
        else $error("motor 2 run ended early");
    a_pins_off: assert property (!EXT_MODE_OUT && !$past(EXT_MODE_OUT) |->
        BRIDGE5_OUT == 2'h0 && BRIDGE6_OUT == 2'h0 && BRIDGE7_OUT == 2'h0)
        else $error("bridges driven with pin mode off");
    a_and_gate: assert property (EXT_MODE_OUT |->
        (BRIDGE5_OUT & ~$past(BRIDGE5_IN)) == 2'h0)
        else $error("bridge 5 not gated by its input");
    a_chop_off: assert property ((EXT_MODE_OUT && CURRENT_SENSE_INPUT_IN
        && BRIDGE7_IN != 2'h3) [*3] |-> BRIDGE7_OUT == 2'h0)
        else $error("bridge 7 not chopped");
endmodule
bind stepper_pulse_ramp_control stepper_pulse_ramp_control_props i_props (.SYS_CLK_IN,
    .NRST_IN, .BRIDGE5_IN, .BRIDGE7_IN, .CURRENT_SENSE_INPUT_IN, .STEP1_OUT, .BUSY1_OUT,
    .STEP2_OUT, .BUSY2_OUT, .EXT_MODE_OUT, .BRIDGE5_OUT, .BRIDGE6_OUT, .BRIDGE7_OUT);
`default_nettype wire

// >>> testbench/stepper_pulse_ramp_control_bench.sv
// self-checking bench driving command words and counting step pulses
`default_nettype none
module stepper_pulse_ramp_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, sclk, sdata, latch, sense, step1, busy1, mon1, step2, busy2, ext;
    logic [1:0] br5, br7, b5o, b7o;
    logic [5:0] ph1, ph2;
    logic [10:0] d2;
    int mismatches, n_compared, n1, m1, n2, n5;
    logic [15:0] modes [3] = '{16'h9610, 16'h9400, 16'h9200};
    stepper_pulse_ramp_control i_dut (.SYS_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1),
        .SCLK_IN(sclk), .SDATA_IN(sdata), .LATCH_IN(latch), .BRIDGE5_IN(br5),
        .BRIDGE6_IN(2'h3), .BRIDGE7_IN(br7), .CURRENT_SENSE_INPUT_IN(sense),
        .STEP1_OUT(step1), .BUSY1_OUT(busy1), .PHASE1_OUT(ph1), .DRIVE1_OUT(),
        .PULSE_MONITOR_OUT_FIRST_OUT(mon1), .STEP2_OUT(step2), .BUSY2_OUT(busy2),
        .PHASE2_OUT(ph2), .DRIVE2_OUT(d2), .PULSE_MONITOR_OUT_SECOND_OUT(),
        .EXT_MODE_OUT(ext), .BRIDGE5_OUT(b5o), .BRIDGE6_OUT(), .BRIDGE7_OUT(b7o));
    host_serial_model i_host (.clk_in(clk), .sclk_out(sclk), .sdata_out(sdata),
        .latch_out(latch));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (step1 === 1'b1) n1++;
        if (mon1 === 1'b1) m1++;
        if (step2 === 1'b1) n2++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // count word starts the run, so the counters clear just before it
    task automatic run(input logic [15:0] a, b, c, d);
        int k;
        i_host.send(a);
        i_host.send(b);
        i_host.send(c);
        n1 = 0;
        m1 = 0;
        n2 = 0;
        i_host.send(d);
        // busy rises two cycles after the frame; the last step lands in the same cycle that busy drops
        repeat (2) @(posedge clk);
        for (k = 0; k < 3000 && (busy1 !== 1'b0 || busy2 !== 1'b0); k++) @(posedge clk);
        @(posedge clk);
        if (k == 3000) chk(16'h0001, 16'h0000);
    endtask
    initial begin
        nrst <= 1'b0;
        br5 <= 2'h2;
        br7 <= 2'h2;
        sense <= 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(16'(ext), 16'h0000);
        run(16'h9002, 16'h80A0, 16'hA001, 16'hB003);
        chk(16'(n1), 16'h0006);
        chk(16'(m1), 16'h0006);
        chk(16'(ph1), 16'h0006);
        foreach (modes[i]) begin
            run(modes[i], 16'h80A0, 16'hA001, 16'hB005);
            chk(16'(n1), 16'h0005);
        end
        $display("motor 1 tests done");
        run(16'hC080, 16'hD003, 16'hE000, 16'hF002);
        chk(16'(n2), 16'h0000);
        run(16'hC080, 16'hD003, 16'hE001, 16'hF002);
        chk(16'(n2), 16'h0008);
        chk(16'(ph2), 16'h0038);
        run(16'hC080, 16'hD001, 16'hE001, 16'hF000);
        chk(16'(n2), 16'h0000);
        run(16'hC080, 16'hD001, 16'hE001, 16'hF002);
        chk(16'(n2), 16'h0002);
        chk(16'(d2), 16'h0080);
        $display("motor 2 tests done");
        i_host.send(16'h5000);
        i_host.send(16'h1001);
        chk(16'(ext), 16'h0001);
        chk(16'(b5o), 16'h0000);
        i_host.send(16'h5080);
        @(posedge clk);
        // half of one 256-cycle pwm period lets input A through
        n5 = 0;
        repeat (256) begin
            @(posedge clk);
            if (b5o === 2'h2) n5++;
        end
        chk(16'(n5), 16'h0080);
        chk(16'(b7o), 16'h0002);
        repeat (300) @(posedge clk);
        sense <= 1'b1;
        repeat (10) @(posedge clk);
        chk(16'(b7o), 16'h0000);
        $display("pin control tests done");
        report_and_stop();
    end
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
